// ---- fspc_consts.svh ----
/*
  Offsets, field positions, reset values and codes for the flash
  self-program control block.
  Assumes it is included by bare name from the package and from fspc_top.
*/
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH

// special-register offsets
`define FSPC_OFF_SECT_HIGH 8'h01
`define FSPC_OFF_SECT_LOW 8'h02
`define FSPC_OFF_UNLOCK 8'h03
`define FSPC_OFF_CONTROL 8'h04

// reset values
`define FSPC_RST_SECT_HIGH 8'h00
`define FSPC_RST_SECT_LOW 8'h00
`define FSPC_RST_UNLOCK 8'h00
`define FSPC_RST_MODE 4'h0

// control register field positions
`define FSPC_CTL_MODE_MSB 7
`define FSPC_CTL_MODE_LSB 4
`define FSPC_CTL_FAIL_BIT 3
`define FSPC_CTL_START_BIT 0

// mode field codes
`define FSPC_MODE_PROGRAM 4'h5
`define FSPC_MODE_ERASE 4'ha
`define FSPC_MODE_LOCK 4'h6

// value that unlocks user programming
`define FSPC_UNLOCK_KEY 8'ha5

// sector select: only bit 7 of the low byte takes part
`define FSPC_SECT_LOW_BIT 7

`endif

// ---- fspc_flash_model.sv ----
/*
  Behavioural flash array answering the controller's requests.
  Assumes the bench sets latency and result before each start.
*/
`timescale 1ns/100ps
module fspc_flash_model
(
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic req, // request
  input wire logic [3:0] lat, // cycles to answer
  input wire logic fail_in, // result to give
  output logic done, // one-cycle answer
  output logic fail // result with done
);
  logic [3:0] cnt;
  logic junk;
  // one done per request; result line toggles when not valid
  always_ff @(posedge clk)
  begin
    junk <= rst ? 1'b0 : ~junk;
    cnt <= (rst || !req || done) ? 4'h0 : cnt + 4'h1;
    done <= !rst && req && !done && cnt == lat;
  end
  assign fail = done ? fail_in : junk;
endmodule

// ---- fspc_monitor.sv ----
/*
  Port checker for the flash self-program control top.
  Assumes it is bound to fspc_top and sees only its ports.
*/
`timescale 1ns/100ps
module fspc_monitor
(
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic ce, // enable
  input wire logic [7:0] reg_addr, // offset
  input wire logic reg_wr, // write
  input wire logic [7:0] reg_wdata, // data
  input wire logic flash_req, // request
  input wire fspc_pkg::fspc_op_t flash_op, // operation
  input wire logic flash_done, // done
  input wire logic [15:0] flash_sector_addr, // pointer
  input wire logic user_prog_enabled, // unlocked
  input wire logic busy // start bit
);
  import fspc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // a start write reaching an idle controller
  sequence s_start;
    ce && reg_wr && reg_addr == 8'h04 && reg_wdata[0] && !busy;
  endsequence
  // the same write carrying a mode code with no operation behind it
  sequence s_bad_start;
    s_start ##0 !(reg_wdata[7:4] inside {4'h5, 4'ha, 4'h6});
  endsequence
  // a request still waiting for the array
  sequence s_wait;
    flash_req && !flash_done;
  endsequence
  // the array answering a held request
  sequence s_done;
    flash_req && flash_done;
  endsequence
  // register writes whose effect shows on the ports from the next edge on
  sequence s_key_write;
    ce && reg_wr && reg_addr == 8'h03;
  endsequence
  sequence s_high_write;
    ce && reg_wr && reg_addr == 8'h01;
  endsequence
  a_start_taken: assert property (s_start |=> busy ##1 (flash_req || !busy))
    else $error("start not taken");
  a_bad_mode: assert property (s_bad_start |=> busy ##1 (!busy && !flash_req))
    else $error("undefined mode ran");
  a_req_valid: assert property (flash_req |-> busy && flash_op != FSPC_OP_NONE)
    else $error("request without operation");
  a_req_unlock: assert property ($rose(flash_req) |-> user_prog_enabled)
    else $error("request while locked out");
  a_req_hold: assert property (s_wait |=> flash_req && $stable(flash_op))
    else $error("request dropped early");
  a_done_clear: assert property (s_done |=> !flash_req ##1 !busy)
    else $error("start bit not cleared");
  a_unlock_key: assert property (s_key_write
    |-> ##2 user_prog_enabled == ($past(reg_wdata, 2) == 8'ha5))
    else $error("unlock key mismatch");
  a_ptr_high: assert property (s_high_write
    |-> ##2 flash_sector_addr[15:8] == $past(reg_wdata, 2))
    else $error("pointer high byte wrong");
endmodule

// ---- fspc_pkg.sv ----
/*
  Types shared by the flash self-program control block.
  Assumes the constants header sits in the same folder.
*/
package fspc_pkg;
  `include "fspc_consts.svh"

  // operation handed to the flash array
  typedef enum logic [1:0]
  {
    FSPC_OP_NONE,
    FSPC_OP_PROGRAM,
    FSPC_OP_ERASE,
    FSPC_OP_LOCK
  } fspc_op_t;

  // sequencer states
  typedef enum logic [1:0]
  {
    FSPC_ST_IDLE,
    FSPC_ST_ACTIVE,
    FSPC_ST_FINISH
  } fspc_state_t;
endpackage

// ---- fspc_seq.sv ----
/*
  Operation sequencer: holds the request to the flash array until the
  array answers, then flags completion for one cycle.
  Assumes the array answers each request with a one-cycle done pulse.
*/
`timescale 1ns/100ps
module fspc_seq
(
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic go, // start bit set and operation allowed
  input wire fspc_pkg::fspc_op_t go_op, // operation to run
  input wire logic array_done, // array finished, one-cycle pulse
  input wire logic array_fail, // array result, valid with array_done
  output logic req, // request to the array, held until done
  output fspc_pkg::fspc_op_t op, // operation presented to the array
  output logic finish, // completion, one cycle
  output logic fail, // result of the finished operation
  output logic idle // no operation in flight
);
  import fspc_pkg::*;

  fspc_state_t state;
  fspc_state_t next_state;
  fspc_op_t next_op;
  logic next_req;
  logic next_fail;

  // next-state logic; the finish state gives the register side one
  // cycle to drop the start bit so the same request is not relaunched
  always_comb
  begin
    next_state = state;
    next_op = op;
    next_req = req;
    next_fail = fail;
    case (state)
      FSPC_ST_IDLE:
      begin
        if (go)
        begin
          next_state = FSPC_ST_ACTIVE;
          next_op = go_op;
          next_req = 1'b1;
        end
      end
      FSPC_ST_ACTIVE:
      begin
        if (array_done)
        begin
          next_state = FSPC_ST_FINISH;
          next_req = 1'b0;
          next_fail = array_fail;
        end
      end
      FSPC_ST_FINISH:
      begin
        next_state = FSPC_ST_IDLE;
        next_op = FSPC_OP_NONE;
      end
      default:
      begin
        next_state = FSPC_ST_IDLE;
        next_op = FSPC_OP_NONE;
        next_req = 1'b0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= FSPC_ST_IDLE;
      op <= FSPC_OP_NONE;
      req <= 1'b0;
      fail <= 1'b0;
      finish <= 1'b0;
      idle <= 1'b1;
    end
    else if (ce)
    begin
      state <= next_state;
      op <= next_op;
      req <= next_req;
      fail <= next_fail;
      finish <= (next_state == FSPC_ST_FINISH);
      idle <= (next_state == FSPC_ST_IDLE);
    end
  end
endmodule

// ---- fspc_top.sv ----
/*
  Flash self-program control: sector pointer, user-programming unlock
  and operation control registers, plus the handshake to the flash array.
  Assumes a CPU special-register port with synchronous byte reads and
  writes, and a flash array that answers each request with a done pulse.
*/
//
// Behaviour
// [RULE_01] mode 0101 selects byte programming
// [RULE_02] mode 1010 erases the pointed sector
// [RULE_03] mode 0110 enters hard lock mode
// [RULE_04] other mode codes select no operation
// [RULE_05] bit 3 shows last erase failed
// [RULE_06] writing start 1 runs; hardware clears it
// [RULE_07] start bit 0 means nothing running
// [RULE_08] high byte gives pointer bits 15..8
// [RULE_09] low byte: only bit 7 selects sector
// [RULE_10] only key 10100101 enables user programming
// [RULE_11] start without unlock or valid mode: cleared
// [RULE_12] software sets pointer first, polls start
`timescale 1ns/100ps
`include "fspc_consts.svh"
module fspc_top
(
  input wire logic clk, // system clock, 40 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [7:0] reg_addr, // special-register offset
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, valid the cycle after reg_rd
  output logic flash_req, // request to the array, held until done
  output fspc_pkg::fspc_op_t flash_op, // operation presented to the array
  output logic [15:0] flash_sector_addr, // sector pointer to the array
  input wire logic flash_done, // array finished, one-cycle pulse
  input wire logic flash_fail, // array result, valid with flash_done
  output logic user_prog_enabled, // unlock key currently loaded
  output logic hard_locked, // hard lock has been entered
  output logic busy // start bit set
);
  import fspc_pkg::*;

  // maps the mode field onto an operation; used for launch and refusal
  function automatic fspc_op_t mode_to_op(input logic [3:0] mode);
    case (mode)
      `FSPC_MODE_PROGRAM: mode_to_op = FSPC_OP_PROGRAM; // see [RULE_01]
      `FSPC_MODE_ERASE: mode_to_op = FSPC_OP_ERASE; // see [RULE_02]
      `FSPC_MODE_LOCK: mode_to_op = FSPC_OP_LOCK; // see [RULE_03]
      default: mode_to_op = FSPC_OP_NONE; // see [RULE_04]
    endcase
  endfunction

  // register state
  logic [7:0] sect_high;
  logic [7:0] sect_low;
  logic [7:0] unlock;
  logic [3:0] mode;
  logic erase_fail;
  logic start;
  logic locked;
  logic [7:0] next_sect_high;
  logic [7:0] next_sect_low;
  logic [7:0] next_unlock;
  logic [3:0] next_mode;
  logic next_erase_fail;
  logic next_start;
  logic next_locked;
  logic [7:0] next_rdata;

  // sequencer side
  fspc_op_t cur_op;
  fspc_op_t seq_op;
  logic seq_req;
  logic seq_finish;
  logic seq_fail;
  logic seq_idle;
  logic enabled;
  logic allowed;
  logic go;
  logic wr_ctl;

  // an operation may launch only when unlocked, the mode is defined and,
  // after a hard lock, only a further lock request; this keeps a locked
  // array safe from a stray program or erase
  always_comb
  begin
    enabled = (unlock == `FSPC_UNLOCK_KEY); // see [RULE_10]
    cur_op = mode_to_op(mode);
    allowed = enabled && (cur_op != FSPC_OP_NONE) // see [RULE_11]
      && !(locked && (cur_op != FSPC_OP_LOCK));
    go = start && allowed; // see [RULE_06]
    wr_ctl = reg_wr && (reg_addr == `FSPC_OFF_CONTROL);
  end

  // register writes and hardware updates
  always_comb
  begin
    next_sect_high = sect_high;
    next_sect_low = sect_low;
    next_unlock = unlock;
    next_mode = mode;
    next_erase_fail = erase_fail;
    next_start = start;
    next_locked = locked;
    if (reg_wr)
    begin
      case (reg_addr)
        `FSPC_OFF_SECT_HIGH: next_sect_high = reg_wdata; // see [RULE_08]
        `FSPC_OFF_SECT_LOW: next_sect_low = reg_wdata; // see [RULE_09]
        `FSPC_OFF_UNLOCK: next_unlock = reg_wdata; // see [RULE_10]
        default: next_unlock = unlock;
      endcase
    end
    // mode and start are frozen while an operation is in flight: the
    // array must see a stable command, and a stop request is not honoured
    if (wr_ctl && !start)
    begin
      next_mode = reg_wdata[`FSPC_CTL_MODE_MSB:`FSPC_CTL_MODE_LSB];
      next_start = reg_wdata[`FSPC_CTL_START_BIT]; // see [RULE_06]
    end
    // refused start drops back to 0 with no array activity
    if (start && seq_idle && !allowed)
    begin
      next_start = 1'b0; // see [RULE_11]
    end
    // completion clears the start bit; an erase records its result, a good lock sets locked
    if (seq_finish)
    begin
      next_start = 1'b0; // see [RULE_06]
      if (seq_op == FSPC_OP_ERASE)
      begin
        next_erase_fail = seq_fail; // see [RULE_05]
      end
      if ((seq_op == FSPC_OP_LOCK) && !seq_fail)
      begin
        next_locked = 1'b1; // see [RULE_03]
      end
    end
  end

  // read mux; bits 2..1 of control and unmapped offsets read zero;
  // rdata holds between reads so a slow poll sees a steady value
  always_comb
  begin
    next_rdata = reg_rdata;
    if (reg_rd)
    begin
      case (reg_addr)
        `FSPC_OFF_SECT_HIGH: next_rdata = sect_high;
        `FSPC_OFF_SECT_LOW: next_rdata = sect_low;
        `FSPC_OFF_UNLOCK: next_rdata = unlock;
        `FSPC_OFF_CONTROL: next_rdata = {mode, erase_fail, 2'b00, start}; // see [RULE_05]
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // register file and output flops
  // ce low freezes every flop here, including the pointer to the array
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sect_high <= `FSPC_RST_SECT_HIGH;
      sect_low <= `FSPC_RST_SECT_LOW;
      unlock <= `FSPC_RST_UNLOCK;
      mode <= `FSPC_RST_MODE;
      erase_fail <= 1'b0;
      start <= 1'b0;
      locked <= 1'b0;
      reg_rdata <= 8'h00;
      flash_sector_addr <= 16'h0000;
      user_prog_enabled <= 1'b0;
      hard_locked <= 1'b0;
      busy <= 1'b0;
    end
    else if (ce)
    begin
      sect_high <= next_sect_high;
      sect_low <= next_sect_low;
      unlock <= next_unlock;
      mode <= next_mode;
      erase_fail <= next_erase_fail;
      start <= next_start;
      locked <= next_locked;
      reg_rdata <= next_rdata;
      // low bits 6..0 are don't-care and never reach the array, so a
      // stale low byte cannot move an erase to a neighbouring sector
      flash_sector_addr <= {next_sect_high, next_sect_low[`FSPC_SECT_LOW_BIT],
        7'h00}; // see [RULE_09]
      user_prog_enabled <= (next_unlock == `FSPC_UNLOCK_KEY); // see [RULE_10]
      hard_locked <= next_locked;
      busy <= next_start; // see [RULE_07]
    end
  end

  // request handshake toward the array
  fspc_seq u_seq
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .go(go),
    .go_op(cur_op),
    .array_done(flash_done),
    .array_fail(flash_fail),
    .req(seq_req),
    .op(seq_op),
    .finish(seq_finish),
    .fail(seq_fail),
    .idle(seq_idle)
  );

  // request and operation come straight from the sequencer's flops
  always_comb
  begin
    flash_req = seq_req;
    flash_op = seq_op;
  end
endmodule

// ---- fspc_top_test.sv ----
/*
  Self-checking bench for the flash self-program control block.
  Assumes the package, checker and flash model are compiled first.
*/
`timescale 1ns/100ps
module fspc_top_test;
  import fspc_pkg::*;
  logic clk, rst, ce, reg_wr, reg_rd, flash_req, flash_done, flash_fail;
  logic user_prog_enabled, hard_locked, busy, fail_in, efail, rd_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, hb;
  logic [15:0] flash_sector_addr;
  logic [3:0] lat;
  logic [31:0] lfsr_s;
  fspc_op_t flash_op;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  localparam logic [3:0] MT [6] = '{4'h5, 4'ha, 4'h3, 4'ha, 4'hf, 4'h0};
  localparam logic FT [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam fspc_op_t OT [6] = '{FSPC_OP_PROGRAM, FSPC_OP_ERASE, FSPC_OP_NONE,
    FSPC_OP_ERASE, FSPC_OP_NONE, FSPC_OP_NONE};
  fspc_top u_fspc_top (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flash_req(flash_req),
    .flash_op(flash_op), .flash_sector_addr(flash_sector_addr), .flash_done(flash_done),
    .flash_fail(flash_fail), .user_prog_enabled(user_prog_enabled),
    .hard_locked(hard_locked), .busy(busy));
  fspc_flash_model u_fspc_flash_model (.clk(clk), .rst(rst), .req(flash_req), .lat(lat),
    .fail_in(fail_in), .done(flash_done), .fail(flash_fail));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  // read data is noted here and compared by the watcher below
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  // start one operation and follow it until the start bit drops; the
  // pointer is left as set before and status is read only once idle again
  task automatic run(input logic [3:0] m, input logic f, input fspc_op_t eo);
    fspc_op_t seen;
    int n;
    seen = FSPC_OP_NONE;
    n = 0;
    lfsr_s = nxt(lfsr_s);
    lat <= lfsr_s[3:0];
    fail_in <= f;
    wr(8'h04, {m, 4'h1});
    while (busy !== 1'b0 && n < 40)
    begin
      if (flash_req === 1'b1)
        seen = flash_op;
      @(posedge clk);
      n++;
    end
    if (eo == FSPC_OP_ERASE)
      efail = f;
    chk(busy, 16'h0);
    chk(seen, eo);
    rd(8'h04, {m, efail, 3'b000});
  endtask
  // read results land one cycle after the strobe is taken
  always @(posedge clk)
  begin
    if (rd_seen === 1'b1)
      chk(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd && ce;
  end
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cut a hang short well past the expected run length
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    {rst, ce, reg_wr, reg_rd, fail_in, efail} = 6'b110000;
    {reg_addr, reg_wdata, lat} = 20'h00002;
    lfsr_s = 32'he544ccd3;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 1; a < 6; a++)
      rd(a[7:0], 8'h00);
    $display("reset value test done");
    lfsr_s = nxt(lfsr_s);
    hb = lfsr_s[15:8];
    wr(8'h01, hb);
    wr(8'h02, lfsr_s[7:0]);
    rd(8'h02, lfsr_s[7:0]);
    chk(flash_sector_addr, {hb, lfsr_s[7], 7'h00});
    $display("pointer test done");
    wr(8'h03, 8'ha4);
    run(4'h5, 1'b0, FSPC_OP_NONE);
    wr(8'h03, 8'ha5);
    chk(user_prog_enabled, 16'h1);
    for (int i = 0; i < 6; i++)
      run(MT[i], FT[i], OT[i]);
    $display("mode test done");
    run(4'h6, 1'b0, FSPC_OP_LOCK);
    chk(hard_locked, 16'h1);
    run(4'h5, 1'b0, FSPC_OP_NONE);
    ce <= 1'b0;
    wr(8'h01, ~hb);
    ce <= 1'b1;
    rd(8'h01, hb);
    $display("lock and freeze test done");
    // one more edge so the watcher compares the last read before closing
    @(posedge clk);
    end_of_test();
  end
endmodule
bind fspc_top fspc_monitor u_fspc_monitor (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .flash_req(flash_req), .flash_op(flash_op),
  .flash_done(flash_done), .flash_sector_addr(flash_sector_addr),
  .user_prog_enabled(user_prog_enabled), .busy(busy));
